// ---- verilog/swrf_pkg.sv ----
// swrf_pkg: shared constants for the stop wake and reset fan-out block
// assumes a single 25 MHz clock; all event inputs already synchronous
package swrf_pkg;
   // wake source vector positions
   localparam int unsigned WK_RESET_PIN   = 0;
   localparam int unsigned WK_WATCHDOG    = 1;
   localparam int unsigned WK_LVD         = 2;
   localparam int unsigned WK_LVW         = 3;
   localparam int unsigned WK_PIN_IRQ     = 4;
   localparam int unsigned WK_CONVERTER   = 5;
   localparam int unsigned WK_COMPARATOR  = 6;
   localparam int unsigned WK_I2C_MATCH   = 7;
   localparam int unsigned WK_LP_SERIAL_A = 8;
   localparam int unsigned WK_LP_SERIAL_B = 9;
   localparam int unsigned WK_SERIAL2_RX  = 10;
   localparam int unsigned WK_RTC         = 11;
   localparam int unsigned WK_NMI_PIN     = 12;
   localparam int unsigned WK_TIMER_PWM   = 13;
   localparam int unsigned WK_LP_TIMER    = 14;
   localparam int unsigned WK_SPI_SLAVE   = 15;
   localparam int unsigned WK_PIO         = 16;
   localparam int unsigned WK_COUNT       = 17;

   // reset source vector positions
   localparam int unsigned RS_POR      = 0;
   localparam int unsigned RS_LVD      = 1;
   localparam int unsigned RS_WAKEUNIT = 2;
   localparam int unsigned RS_PIN      = 3;
   localparam int unsigned RS_WATCHDOG = 4;
   localparam int unsigned RS_STOPACK  = 5;
   localparam int unsigned RS_SOFTWARE = 6;
   localparam int unsigned RS_LOCKUP   = 7;
   localparam int unsigned RS_DEBUGPRT = 8;
   localparam int unsigned RS_DEBUG    = 9;
   localparam int unsigned RS_COUNT    = 10;

   // reset domain positions
   localparam int unsigned DM_POWER   = 0;
   localparam int unsigned DM_SYSINT  = 1;
   localparam int unsigned DM_MODE    = 2;
   localparam int unsigned DM_CAUSE   = 3;
   localparam int unsigned DM_WAKE    = 4;
   localparam int unsigned DM_RTC     = 5;
   localparam int unsigned DM_LPTIMER = 6;
   localparam int unsigned DM_OTHERS  = 7;
   localparam int unsigned DM_COUNT   = 8;

   // per-source domain masks, bit order as DM_* (others at bit 7)
   localparam logic [7:0] MASK_POR      = 8'hff;
   localparam logic [7:0] MASK_LVD      = 8'hdf;
   localparam logic [7:0] MASK_WAKEUNIT = 8'h8a;
   localparam logic [7:0] MASK_SYSTEM   = 8'h9f;

   // reset release synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;

   // retained register file
   localparam int unsigned RF_BYTES  = 32;
   localparam int unsigned RF_ADDR_W = 5;
   localparam logic [7:0]  RF_RESET  = 8'h00;

   typedef enum logic [1:0] {
      SWRF_PM_RUN,
      SWRF_PM_WAIT,
      SWRF_PM_STOP
   } swrf_pmode_e;
endpackage

// ---- verilog/swrf_reset_sync.sv ----
// swrf_reset_sync: asserts a domain reset at once, releases it on the clock
// assumes clock_in is the clock of the domain the output drives
`timescale 1ns/10ps
module swrf_reset_sync (
   input  wire logic clock_in,
   input  wire logic req_in,
   output logic      rst_n_out
);
   logic [swrf_pkg::SYNC_STAGES-1:0] chain_reg;

   // asynchronous assertion, two-stage clocked release
   always_ff @(posedge clock_in or posedge req_in) begin
      if (req_in) begin
         chain_reg <= '0;
      end else begin
         chain_reg <= {chain_reg[swrf_pkg::SYNC_STAGES-2:0], 1'b1};
      end
   end

   assign rst_n_out = chain_reg[swrf_pkg::SYNC_STAGES-1];
endmodule // swrf_reset_sync

// ---- verilog/swrf_top.sv ----
// swrf_top: stop-mode wake detection, reset fan-out and retained register file
// assumes all inputs synchronous to clock_in; por_n comes from rst_n_in
`timescale 1ns/10ps

// What this block does
// - wake detector requests clocks in stop unclocked
// - pending wake interrupt held for interrupt controller
// - wakes from stop and very-low-power stop
// - interrupt controller wakes from both wait modes
// - reset pin wakes if filter off/low_power_osc
// - watchdog wakes; runs in stop when clocked
// - voltage detect and warning accepted as wake
// - any enabled pin interrupt wakes stop
// - converter wakes only on internal/crystal clock
// - comparator wakes in normal or triggered mode
// - rtc, nmi, i2c, serial2 edge, spi wake
// - clocked lp serial, timers, pio wake
// - marked source clears module except exclusions
// - unmarked source leaves module state intact
// - por clears all; lvd spares rtc only; others spare rtc/timer
// - wake-unit reset spares power/mode/wake/rtc/timer
// - register file retained; cleared only by por
module swrf_top (
   input  wire logic                                clock_in,
   input  wire logic                                rst_n_in,
   // power mode from the mode controller
   input  wire logic [1:0]                          power_mode_in,
   input  wire logic                                very_low_power_in,
   // wake event lines and their enables
   input  wire logic [swrf_pkg::WK_COUNT-1:0]       wake_event_in,
   input  wire logic [swrf_pkg::WK_COUNT-1:0]       wake_enable_in,
   // qualifiers for conditional sources
   input  wire logic                                pin_filter_en_in,
   input  wire logic                                pin_filter_lpo_in,
   input  wire logic                                watchdog_clk_on_in,
   input  wire logic                                converter_clk_ok_in,
   input  wire logic                                comparator_mode_ok_in,
   input  wire logic                                lp_serial_a_clk_in,
   input  wire logic                                lp_serial_b_clk_in,
   input  wire logic                                timer_pwm_clk_in,
   input  wire logic                                lp_timer_clk_in,
   input  wire logic                                pio_clk_in,
   // interrupt controller handshake
   input  wire logic                                irq_any_pending_in,
   input  wire logic                                wake_ack_in,
   // reset requests (excluding power-on, which is rst_n_in)
   input  wire logic [swrf_pkg::RS_COUNT-1:0]       reset_req_in,
   input  wire logic                                deep_stop_pin_wake_in,
   // retained register file port
   input  wire logic                                rf_write_in,
   input  wire logic [swrf_pkg::RF_ADDR_W-1:0]      rf_addr_in,
   input  wire logic [7:0]                          rf_wdata_in,
   output logic [7:0]                               rf_rdata_out,
   // outputs
   output logic                                     clock_restart_out,
   output logic                                     wake_pending_out,
   output logic [swrf_pkg::WK_COUNT-1:0]            wake_source_out,
   output logic                                     core_wake_out,
   output logic [swrf_pkg::DM_COUNT-1:0]            domain_rst_n_out,
   output logic                                     reset_pin_negate_out,
   output logic [swrf_pkg::RS_COUNT-1:0]            reset_cause_out
);
   typedef enum logic [1:0] {
      SWRF_ST_RUN,
      SWRF_ST_ARMED,
      SWRF_ST_RESTART
   } swrf_state_e;

   swrf_state_e                           state_reg;
   swrf_state_e                           state_next;
   logic [swrf_pkg::WK_COUNT-1:0]         qualified;
   logic [swrf_pkg::WK_COUNT-1:0]         pend_reg;
   logic [swrf_pkg::RS_COUNT-1:0]         req_all;
   logic [swrf_pkg::DM_COUNT-1:0]         dom_req;
   logic [swrf_pkg::RS_COUNT-1:0]         cause_reg;
   logic                                  pin_negate_reg;
   logic [7:0]                            rf_mem [swrf_pkg::RF_BYTES];
   logic                                  in_stop;
   logic                                  in_wait;

   // domain mask for a reset source
   function automatic logic [7:0] src_mask(input int unsigned src);
      case (src)
         swrf_pkg::RS_POR:      src_mask = swrf_pkg::MASK_POR;
         swrf_pkg::RS_LVD:      src_mask = swrf_pkg::MASK_LVD;
         swrf_pkg::RS_WAKEUNIT: src_mask = swrf_pkg::MASK_WAKEUNIT;
         default:               src_mask = swrf_pkg::MASK_SYSTEM;
      endcase
   endfunction

   assign in_stop = (power_mode_in == 2'(swrf_pkg::SWRF_PM_STOP));
   assign in_wait = (power_mode_in == 2'(swrf_pkg::SWRF_PM_WAIT));

   // per-source qualification of wake events
   always_comb begin
      qualified = wake_event_in & wake_enable_in;
      // pin wakes only with the filter off or filtered from low_power_osc
      qualified[swrf_pkg::WK_RESET_PIN] = wake_event_in[swrf_pkg::WK_RESET_PIN] &
         (~pin_filter_en_in | pin_filter_lpo_in);
      qualified[swrf_pkg::WK_WATCHDOG] = wake_event_in[swrf_pkg::WK_WATCHDOG] &
         watchdog_clk_on_in;
      qualified[swrf_pkg::WK_LVD] = wake_event_in[swrf_pkg::WK_LVD];
      qualified[swrf_pkg::WK_LVW] = wake_event_in[swrf_pkg::WK_LVW];
      qualified[swrf_pkg::WK_CONVERTER] = qualified[swrf_pkg::WK_CONVERTER] &
         converter_clk_ok_in;
      qualified[swrf_pkg::WK_COMPARATOR] = qualified[swrf_pkg::WK_COMPARATOR] &
         comparator_mode_ok_in;
      qualified[swrf_pkg::WK_LP_SERIAL_A] = qualified[swrf_pkg::WK_LP_SERIAL_A] &
         lp_serial_a_clk_in;
      qualified[swrf_pkg::WK_LP_SERIAL_B] = qualified[swrf_pkg::WK_LP_SERIAL_B] &
         lp_serial_b_clk_in;
      qualified[swrf_pkg::WK_TIMER_PWM] = qualified[swrf_pkg::WK_TIMER_PWM] &
         timer_pwm_clk_in;
      qualified[swrf_pkg::WK_LP_TIMER] = qualified[swrf_pkg::WK_LP_TIMER] &
         lp_timer_clk_in;
      qualified[swrf_pkg::WK_PIO] = qualified[swrf_pkg::WK_PIO] & pio_clk_in;
      // pin irq, i2c, serial2 edge, rtc, nmi and spi pass on their enable alone
   end

   // wake state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SWRF_ST_RUN: begin
            if (in_stop) begin
               state_next = SWRF_ST_ARMED;
            end
         end
         SWRF_ST_ARMED: begin
            if (|qualified) begin
               state_next = SWRF_ST_RESTART;
            end else if (!in_stop) begin
               state_next = SWRF_ST_RUN;
            end
         end
         SWRF_ST_RESTART: begin
            if (!in_stop) begin
               state_next = SWRF_ST_RUN;
            end
         end
         default: state_next = SWRF_ST_RUN;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= SWRF_ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // pending wake sources held until acknowledged; ack is ignored while armed
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend_reg <= '0;
      end else if (state_reg == SWRF_ST_ARMED) begin
         pend_reg <= pend_reg | qualified;
      end else if (wake_ack_in) begin
         pend_reg <= '0;
      end
   end

   // the restart request is combinational so it needs no running edge to assert
   assign clock_restart_out = (state_reg == SWRF_ST_ARMED) & (|qualified);
   assign wake_pending_out  = |pend_reg;
   assign wake_source_out   = pend_reg;
   assign core_wake_out     = clock_restart_out |
                              (in_wait & irq_any_pending_in);

   // reset fan-out: power-on comes from rst_n_in
   always_comb begin
      req_all = reset_req_in;
      req_all[swrf_pkg::RS_POR] = ~rst_n_in;
      dom_req = '0;
      for (int unsigned s = 0; s < swrf_pkg::RS_COUNT; s++) begin
         if (req_all[s]) begin
            dom_req = dom_req | src_mask(s);
         end
      end
      // unmarked domains simply get no request from that source
   end

   for (genvar d = 0; d < swrf_pkg::DM_COUNT; d++) begin : g_dom
      swrf_reset_sync u_sync (
         .clock_in  (clock_in),
         .req_in    (dom_req[d]),
         .rst_n_out (domain_rst_n_out[d])
      );
   end

   // reset pin negation follows the wake-unit case only when the pin woke deep stop
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_negate_reg <= 1'b1;
      end else if (req_all[swrf_pkg::RS_WAKEUNIT]) begin
         pin_negate_reg <= deep_stop_pin_wake_in;
      end else begin
         pin_negate_reg <= |req_all;
      end
   end
   assign reset_pin_negate_out = pin_negate_reg;

   // reset cause capture: power-on loads 10'h001, any other request overwrites it with req_all
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cause_reg <= 10'h001;
      end else if (|req_all) begin
         cause_reg <= req_all;
      end
   end
   assign reset_cause_out = cause_reg;

   // retained register file: only power-on clears it
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int unsigned i = 0; i < swrf_pkg::RF_BYTES; i++) begin
            rf_mem[i] <= swrf_pkg::RF_RESET;
         end
      end else if (rf_write_in) begin
         rf_mem[rf_addr_in] <= rf_wdata_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rf_rdata_out <= 8'h00;
      end else begin
         rf_rdata_out <= rf_mem[rf_addr_in];
      end
   end
endmodule // swrf_top

// ---- sim/swrf_chk.sv ----
// swrf_chk: port assertions for swrf_top wake detection and reset fan-out
// assumes one clock domain and the package domain and source bit order
`timescale 1ns/10ps
module swrf_chk (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic [1:0]  power_mode_in,
   input wire logic [16:0] wake_event_in,
   input wire logic        irq_any_pending_in,
   input wire logic [9:0]  reset_req_in,
   input wire logic        deep_stop_pin_wake_in,
   input wire logic        clock_restart_out,
   input wire logic        wake_pending_out,
   input wire logic        core_wake_out,
   input wire logic [7:0]  domain_rst_n_out,
   input wire logic        reset_pin_negate_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   chk_sys_clear: assert property (|reset_req_in[9:3] |-> (domain_rst_n_out & 8'h9f) == 8'h00)
      else $error("system reset left a domain running");
   chk_lvd_clear: assert property (reset_req_in[1] |-> (domain_rst_n_out & 8'hdf) == 8'h00)
      else $error("voltage reset left a domain running");
   chk_wu_clear: assert property (reset_req_in[2] |-> (domain_rst_n_out & 8'h8a) == 8'h00)
      else $error("wake unit reset left a domain running");
   chk_rtc_kept: assert property (!$fell(domain_rst_n_out[5]))
      else $error("clock domain reset outside power-on");
   chk_wake_kept: assert property ($fell(domain_rst_n_out[4]) |-> |(reset_req_in & 10'h3fa))
      else $error("wake domain reset by wake unit reset");
   chk_sync_rel: assert property ($rose(domain_rst_n_out[7])
      |-> reset_req_in[9:1] == 9'h000 && $past(reset_req_in[9:1], 2) == 9'h000)
      else $error("domain released too early");
   chk_pend_set: assert property (clock_restart_out |=> wake_pending_out)
      else $error("restart without pending wake");
   chk_restart_src: assert property (clock_restart_out |-> (|wake_event_in) && core_wake_out)
      else $error("restart without event or core wake");
   chk_wait_wake: assert property (power_mode_in == 2'h1 && irq_any_pending_in |-> core_wake_out)
      else $error("wait mode not woken by interrupt");
   chk_pin_negate: assert property (reset_req_in == 10'h004
      |=> reset_pin_negate_out == $past(deep_stop_pin_wake_in))
      else $error("pin negate wrong on wake unit reset");
endmodule // swrf_chk

bind swrf_top swrf_chk u_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .power_mode_in(power_mode_in),
   .wake_event_in(wake_event_in), .irq_any_pending_in(irq_any_pending_in), .reset_req_in(reset_req_in),
   .deep_stop_pin_wake_in(deep_stop_pin_wake_in), .clock_restart_out(clock_restart_out),
   .wake_pending_out(wake_pending_out), .core_wake_out(core_wake_out),
   .domain_rst_n_out(domain_rst_n_out), .reset_pin_negate_out(reset_pin_negate_out));

// ---- sim/swrf_wake_src.sv ----
// swrf_wake_src: peripheral wake sources and clock control acknowledge
// assumes fire and drop come from the bench on rising edges
`timescale 1ns/10ps
module swrf_wake_src (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic        fire_in,
   input  wire logic [4:0]  sel_in,
   input  wire logic        drop_in,
   input  wire logic        restart_in,
   output logic      [16:0] event_out
);
   // a flag stays up until clocks run again or software would service it
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) event_out <= 17'h00000;
      else if (drop_in || restart_in) event_out <= 17'h00000;
      else if (fire_in) event_out <= 17'h00001 << sel_in;
   end
endmodule // swrf_wake_src

// ---- sim/swrf_tb.sv ----
// testbench: wake sources, gating, wait wake, reset fan-out and retention
// assumes swrf_wake_src stands for the peripherals on the far side
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, vlp = 1'b0, irq = 1'b0, ack = 1'b0, dsp = 1'b0;
   logic        rfw = 1'b0, fire = 1'b0, drop = 1'b0, pfe = 1'b1;
   logic        crs, pend, cw, pneg;
   logic [1:0]  pm = 2'h0;
   logic [4:0]  ra = 5'h1f, sel = 5'h00;
   logic [7:0]  wd = 8'h00, rd, dom;
   logic [8:0]  gate = 9'h1ff;
   logic [9:0]  rq = 10'h000, rc;
   logic [16:0] wen = 17'h1ffff, wev, ws;
   int          fail_count = 0, n_tests = 0, cycles = 0;
   always #20 clk = ~clk;
   swrf_wake_src src (.clock_in(clk), .rst_n_in(rst_n), .fire_in(fire), .sel_in(sel), .drop_in(drop),
      .restart_in(crs), .event_out(wev));
   swrf_top dut (.clock_in(clk), .rst_n_in(rst_n), .power_mode_in(pm), .very_low_power_in(vlp),
      .wake_event_in(wev), .wake_enable_in(wen), .pin_filter_en_in(pfe), .pin_filter_lpo_in(gate[0]),
      .watchdog_clk_on_in(gate[1]), .converter_clk_ok_in(gate[2]), .comparator_mode_ok_in(gate[3]),
      .lp_serial_a_clk_in(gate[4]), .lp_serial_b_clk_in(gate[5]), .timer_pwm_clk_in(gate[6]),
      .lp_timer_clk_in(gate[7]), .pio_clk_in(gate[8]), .irq_any_pending_in(irq), .wake_ack_in(ack),
      .reset_req_in(rq), .deep_stop_pin_wake_in(dsp), .rf_write_in(rfw), .rf_addr_in(ra),
      .rf_wdata_in(wd), .rf_rdata_out(rd), .clock_restart_out(crs), .wake_pending_out(pend),
      .wake_source_out(ws), .core_wake_out(cw), .domain_rst_n_out(dom),
      .reset_pin_negate_out(pneg), .reset_cause_out(rc));
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ack only after the mode has left stop, as the controller expects
   task run_wake(input int k, input logic ok);
      @(posedge clk);
      pm <= 2'h2;
      vlp <= k[0];
      sel <= k[4:0];
      cyc(2);
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      @(negedge clk); chk(crs, ok); chk(cw, ok);
      @(negedge clk); chk(pend, ok);
      if (ok) chk(ws, 17'h1 << k);
      @(posedge clk); pm <= 2'h0; drop <= 1'b1;
      cyc(1); ack <= 1'b1; drop <= 1'b0;
      cyc(1); ack <= 1'b0;
      @(negedge clk); chk(pend, 1'b0);
   endtask
   // last entry: filter off with no low_power_osc clock must still let the pin wake
   task t_gates;
      int s[11] = '{0, 1, 5, 6, 8, 9, 13, 14, 16, 4, 0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         if (i < 9) gate <= ~(9'h1 << i);
         else if (i == 9) wen <= ~17'h10;
         else begin
            wen <= 17'h1ffff;
            gate <= 9'h1fe;
            pfe <= 1'b0;
         end
         run_wake(s[i], i == 10);
      end
      @(posedge clk);
      gate <= 9'h1ff;
      wen <= 17'h1ffff;
      pfe <= 1'b1;
   endtask
   task t_wait;
      @(posedge clk); pm <= 2'h1; vlp <= 1'b1; irq <= 1'b1;
      @(negedge clk); chk(cw, 1'b1);
      @(posedge clk); pm <= 2'h0;
      @(negedge clk); chk(cw, 1'b0);
      @(posedge clk); irq <= 1'b0;
   endtask
   // last pass repeats the wake-unit reset with the pin having woken deep stop
   task t_fanout;
      logic [7:0] m;
      int         s;
      for (int k = 1; k < 11; k++) begin
         s = (k == 10) ? 2 : k;
         m = (s == 1) ? 8'hdf : (s == 2) ? 8'h8a : 8'h9f;
         @(posedge clk); rq <= 10'h1 << s; dsp <= k[0] | (k == 10);
         @(negedge clk); chk(dom, 8'(~m));
         @(posedge clk); rq <= 10'h000;
         @(negedge clk); chk(pneg, s != 2 || k == 10);
         chk(rc, 10'h1 << s);
         cyc(2);
         @(negedge clk); chk(dom, 8'hff);
      end
   endtask
   task t_retain;
      @(posedge clk); rfw <= 1'b1; wd <= 8'ha5;
      @(posedge clk); rfw <= 1'b0; rq <= 10'h3fe;
      @(posedge clk); rq <= 10'h000; pm <= 2'h2;
      cyc(3);
      @(negedge clk); chk(rd, 8'ha5);
      chk(rc, 10'h3fe);
      @(posedge clk); rst_n <= 1'b0;
      @(negedge clk); chk(dom, 8'h00); chk(rc, 10'h001);
      @(posedge clk); rst_n <= 1'b1; pm <= 2'h0;
      cyc(3);
      @(negedge clk); chk(rd, 8'h00);
   endtask
   // run length is well under this ceiling; reaching it means a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      cyc(12);
      rst_n <= 1'b1;
      cyc(3);
      @(negedge clk); chk(dom, 8'hff);
      for (int k = 0; k < 17; k++) run_wake(k, 1'b1);
      t_gates();
      t_wait();
      t_fanout();
      t_retain();
      close_out();
   end
endmodule // testbench
